// ===== hdl/usmf_pkg.sv
// Constants, register map and state codes of the USART modem front end.
// Assumes a single 200 MHz clock and an AXI4-Lite register bus.
package usmf_pkg;
  // ****
  // Sizes and timing
  // ****
  localparam int FIFO_DEPTH = 16;
  localparam int OVS        = 16;
  localparam int OVS_MID    = 8;
  localparam int ADDR_W     = 6;
  localparam int ADDR_LSB   = 2;
  localparam int IDX_W      = 4;
  localparam int N_IN       = 5;
  // ****
  // Register indices (byte address = 4 * index)
  // ****
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_IER  = 4'h1;
  localparam logic [3:0] IDX_IIR  = 4'h2;
  localparam logic [3:0] IDX_LCR  = 4'h3;
  localparam logic [3:0] IDX_MCR  = 4'h4;
  localparam logic [3:0] IDX_LSR  = 4'h5;
  localparam logic [3:0] IDX_MSR  = 4'h6;
  localparam logic [3:0] IDX_SCR  = 4'h7;
  localparam logic [3:0] IDX_MODE = 4'h8;
  // ****
  // Field positions
  // ****
  localparam int LCR_DLAB  = 7;
  localparam int MCR_DTR   = 0;
  localparam int MCR_RTS   = 1;
  localparam int MCR_OUT1  = 2;
  localparam int MCR_OUT2  = 3;
  localparam int MCR_LOOP  = 4;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int FCR_TRIG  = 6;
  localparam int MODE_HDX  = 0;
  localparam int MODE_SYNC = 1;
  localparam int MODE_ACTS = 2;
  localparam int MODE_485  = 3;
  localparam int IN_RX     = 0;
  localparam int IN_CTS    = 1;
  localparam int IN_DSR    = 2;
  localparam int IN_RI     = 3;
  localparam int IN_DCD    = 4;
  // ****
  // Values
  // ****
  localparam logic [15:0] DIV_RST   = 16'h0001;
  localparam logic [7:0]  IIR_VAL   = 8'hc1;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;
  localparam logic [4:0]  TRIG_1    = 5'h01;
  localparam logic [4:0]  TRIG_4    = 5'h04;
  localparam logic [4:0]  TRIG_8    = 5'h08;
  localparam logic [4:0]  TRIG_14   = 5'h0e;
  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_START = 2'b01,
    SER_DATA  = 2'b10,
    SER_STOP  = 2'b11
  } usmf_ser_t;
endpackage

// ===== hdl/usmf_top.sv
// USART front end: 16550-style registers, FIFOs, 8N1 link, modem pins.
// Assumes asynchronous pins; the single wire is resolved from serial_tx_oe.
// Summary of operation
// RULE1 - Full-duplex NRZ async on separate lines
// RULE2 - Half-duplex mode shares one line
// RULE3 - Sync mode drives clock with data
// RULE4 - Sixteen-byte transmit and receive FIFOs
// RULE5 - Receive trigger at 1, 4, 8, 14
// RULE6 - Registers at 16550 locations
// RULE7 - Software or hardware flow control
// RULE8 - Clear-to-send shown at status bit 4
// RULE9 - Request-to-send low when control bit 1
// RULE10 - Request-to-send doubles as RS-485 direction
// RULE11 - Terminal-ready low when control bit 0
// RULE12 - Loopback holds both outputs inactive
// RULE13 - Set-ready shown at status bit 5
// RULE14 - Carrier-detect shown at status bit 7
// RULE15 - Ring shown at status bit 6
// RULE16 - Auto-CTS: start only while pin low
// RULE17 - Low modem pin reads as one
`timescale 1ns/10ps
`default_nettype none
module usmf_top
  import usmf_pkg::*;
#(
  parameter int DEPTH = usmf_pkg::FIFO_DEPTH
) (
  input  wire logic                       aclk,           // Clock
  input  wire logic                       aresetn,        // Sync reset, low
  input  wire logic                       s_awvalid,      // AW valid
  output logic                            s_awready,      // AW ready
  input  wire logic [usmf_pkg::ADDR_W-1:0] s_awaddr,      // AW address
  input  wire logic                       s_wvalid,       // W valid
  output logic                            s_wready,       // W ready
  input  wire logic [31:0]                s_wdata,        // W data
  input  wire logic [3:0]                 s_wstrb,        // W strobes
  output logic                            s_bvalid,       // B valid
  input  wire logic                       s_bready,       // B ready
  output logic [1:0]                      s_bresp,        // B response
  input  wire logic                       s_arvalid,      // AR valid
  output logic                            s_arready,      // AR ready
  input  wire logic [usmf_pkg::ADDR_W-1:0] s_araddr,      // AR address
  output logic                            s_rvalid,       // R valid
  input  wire logic                       s_rready,       // R ready
  output logic [31:0]                     s_rdata,        // R data
  output logic [1:0]                      s_rresp,        // R response
  output logic                            serial_tx_out,  // Serial data out
  output logic                            serial_tx_oe,   // Drive enable
  input  wire logic                       serial_rx_in,   // Serial data in
  output logic                            sync_clock_out, // Sync clock
  input  wire logic                       clear_to_send_in,    // Low active
  output logic                            request_to_send_out, // Low active
  output logic                            terminal_ready_out,  // Low active
  input  wire logic                       set_ready_in,        // Low active
  input  wire logic                       carrier_detect_in,   // Low active
  input  wire logic                       ring_indicator_in    // Low active
);
  import usmf_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [3:0] OVS_END = 4'(OVS - 1);
  localparam logic [3:0] MID_END = 4'(OVS_MID - 1);
  localparam logic [3:0] MID     = 4'(OVS_MID);

  // ****
  // State
  // ****
  typedef struct packed {
    logic [2:0][N_IN-1:0]     sy;
    logic [N_IN-1:0]          pin;
    logic [15:0]              div;
    logic [15:0]              bcnt;
    logic [7:0]               lcr;
    logic [7:0]               mcr;
    logic [7:0]               scr;
    logic [3:0]               mode;
    logic [1:0]               trig;
    logic [DEPTH-1:0][7:0]    txm;
    logic [DEPTH-1:0][7:0]    rxm;
    logic [PW-1:0]            txw;
    logic [PW-1:0]            txr;
    logic [PW-1:0]            rxw;
    logic [PW-1:0]            rxr;
    logic [CW-1:0]            txc;
    logic [CW-1:0]            rxc;
    usmf_ser_t                txs;
    logic [3:0]               txo;
    logic [2:0]               txb;
    logic [7:0]               txsh;
    logic                     txd;
    usmf_ser_t                rxs;
    logic [3:0]               rxo;
    logic [2:0]               rxb;
    logic [7:0]               rxsh;
    logic                     ovr;
    logic                     fe;
    logic [3:0]               dmsr;
    logic [3:0]               mprev;
    logic                     sclk;
    logic                     awh;
    logic                     wh;
    logic [3:0]               awi;
    logic [7:0]               wd;
    logic                     wbe;
    logic                     bv;
    logic [1:0]               br;
    logic                     rv;
    logic [1:0]               rr;
    logic [7:0]               rd;
  } usmf_st_t;

  localparam usmf_st_t ST_RST = '{
    sy: '1, pin: '1, div: DIV_RST, txs: SER_IDLE, rxs: SER_IDLE,
    txd: 1'b1, default: '0
  };

  usmf_st_t q;
  usmf_st_t d;

  logic            tick;
  logic            loop;
  logic            rx_line;
  logic [3:0]      msr_now;
  logic [4:0]      trig_lvl;
  logic            tx_busy;
  logic            cts_ok;
  logic            tpush;
  logic            tpop;
  logic            rpush;
  logic            rpop;
  logic [3:0]      ari;
  logic [7:0]      rval;

  // ****
  // Next state
  // ****
  always_comb begin
    d = q;
    tpush = 1'b0;
    tpop = 1'b0;
    rpush = 1'b0;
    rpop = 1'b0;
    rval = '0;
    ari = s_araddr[ADDR_LSB +: IDX_W];
    loop = q.mcr[MCR_LOOP];
    tx_busy = (q.txs != SER_IDLE);

    // A level counts once stages two and three agree: no glitches
    d.sy[0] = {carrier_detect_in, ring_indicator_in, set_ready_in,
               clear_to_send_in, serial_rx_in};
    d.sy[1] = q.sy[0];
    d.sy[2] = q.sy[1];
    for (int i = 0; i < N_IN; i++) begin
      if (q.sy[1][i] == q.sy[2][i]) begin
        d.pin[i] = q.sy[1][i];
      end
    end

    // Status bits are asserted-high; loopback feeds them from control
    if (loop) begin
      msr_now = {q.mcr[MCR_OUT2], q.mcr[MCR_OUT1],
                 q.mcr[MCR_DTR], q.mcr[MCR_RTS]};
    end else begin
      msr_now = ~{q.pin[IN_DCD], q.pin[IN_RI], // see RULE14 RULE15 RULE17
                  q.pin[IN_DSR], q.pin[IN_CTS]};
    end
    cts_ok = msr_now[0];
    rx_line = loop ? q.txd : q.pin[IN_RX]; // see RULE1

    unique case (q.trig) // see RULE5
      2'h0: trig_lvl = TRIG_1;
      2'h1: trig_lvl = TRIG_4;
      2'h2: trig_lvl = TRIG_8;
      2'h3: trig_lvl = TRIG_14;
    endcase

    // Tick at sixteen times the bit rate
    tick = (q.bcnt == '0);
    if (tick) begin
      d.bcnt = (q.div == '0) ? '0 : q.div - 16'h0001;
    end else begin
      d.bcnt = q.bcnt - 16'h0001;
    end

    // ****
    // AXI4-Lite write path
    // ****
    if (s_awvalid && s_awready) begin
      d.awh = 1'b1;
      d.awi = s_awaddr[ADDR_LSB +: IDX_W];
    end
    if (s_wvalid && s_wready) begin
      d.wh = 1'b1;
      d.wd = s_wdata[7:0];
      d.wbe = s_wstrb[0];
    end
    if (q.bv && s_bready) begin
      d.bv = 1'b0;
    end
    if (q.awh && q.wh) begin
      d.awh = 1'b0;
      d.wh = 1'b0;
      d.bv = 1'b1;
      d.br = (q.awi > IDX_MODE) ? RESP_SLV : RESP_OKAY;
      if (q.wbe) begin
        unique case (q.awi) // see RULE6
          IDX_DATA: begin
            if (q.lcr[LCR_DLAB]) begin
              d.div[7:0] = q.wd;
            end else begin
              tpush = (q.txc != FULL); // Full queue drops the byte
            end
          end
          IDX_IER: begin
            if (q.lcr[LCR_DLAB]) begin
              d.div[15:8] = q.wd;
            end
          end
          IDX_IIR: d.trig = q.wd[FCR_TRIG +: 2];
          IDX_LCR: d.lcr = q.wd;
          IDX_MCR: d.mcr = q.wd; // see RULE7
          IDX_SCR: d.scr = q.wd;
          IDX_MODE: d.mode = q.wd[3:0];
          default: ;
        endcase
      end
    end

    // ****
    // AXI4-Lite read path, with read side effects
    // ****
    if (q.rv && s_rready) begin
      d.rv = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      d.rv = 1'b1;
      d.rr = (ari > IDX_MODE) ? RESP_SLV : RESP_OKAY;
      unique case (ari)
        IDX_DATA: begin
          if (q.lcr[LCR_DLAB]) begin
            rval = q.div[7:0];
          end else begin
            rval = q.rxm[q.rxr];
            rpop = (q.rxc != '0);
          end
        end
        IDX_IER: rval = q.lcr[LCR_DLAB] ? q.div[15:8] : 8'h00;
        IDX_IIR: rval = IIR_VAL;
        IDX_LCR: rval = q.lcr;
        IDX_MCR: rval = q.mcr;
        IDX_LSR: begin
          rval = {1'b0, !tx_busy && q.txc == '0, q.txc == '0,
                  1'b0, q.fe, 1'b0, q.ovr, q.rxc != '0};
          d.ovr = 1'b0;
          d.fe = 1'b0;
        end
        IDX_MSR: begin
          rval = {msr_now, q.dmsr}; // see RULE8
          d.dmsr = '0;
        end
        IDX_SCR: rval = q.scr;
        IDX_MODE: rval = {q.rxc >= CW'(trig_lvl), 3'h0, q.mode};
        default: rval = 8'h00;
      endcase
      d.rd = rval;
    end

    // Change flags: a change in the same cycle as the read survives
    d.mprev = msr_now;
    d.dmsr = d.dmsr | (msr_now ^ q.mprev); // see RULE13

    // ****
    // Transmitter
    // ****
    unique case (q.txs)
      SER_IDLE: begin
        // Auto-CTS gates only the start of a character
        if (q.txc != '0 && (!q.mode[MODE_ACTS] || cts_ok)) begin  // see RULE16
          tpop = 1'b1;
          d.txsh = q.txm[q.txr];
          d.txs = SER_START;
          d.txo = '0;
          d.txd = 1'b0;
        end
      end
      SER_START: begin
        if (tick) begin
          d.txo = q.txo + 4'h1;
          if (q.txo == OVS_END) begin
            d.txs = SER_DATA;
            d.txb = '0;
            d.txd = q.txsh[0];
          end
        end
      end
      SER_DATA: begin
        if (tick) begin
          d.txo = q.txo + 4'h1;
          if (q.txo == OVS_END) begin
            d.txsh = {1'b0, q.txsh[7:1]};
            if (q.txb == 3'h7) begin
              d.txs = SER_STOP;
              d.txd = 1'b1;
            end else begin
              d.txb = q.txb + 3'h1;
              d.txd = q.txsh[1];
            end
          end
        end
      end
      SER_STOP: begin
        if (tick) begin
          d.txo = q.txo + 4'h1;
          if (q.txo == OVS_END) begin
            d.txs = SER_IDLE;
          end
        end
      end
    endcase
    // Clock is high in the second half of each data bit
    d.sclk = q.mode[MODE_SYNC] && d.txs == SER_DATA && d.txo >= MID;  // see RULE3

    // ****
    // Receiver
    // ****
    unique case (q.rxs)
      SER_IDLE: begin
        if (!rx_line) begin
          d.rxs = SER_START;
          d.rxo = '0;
        end
      end
      SER_START: begin
        if (tick) begin
          d.rxo = q.rxo + 4'h1;
          if (q.rxo == MID_END) begin
            d.rxo = '0;
            d.rxb = '0;
            // A start bit gone by mid-bit was noise
            d.rxs = rx_line ? SER_IDLE : SER_DATA;
          end
        end
      end
      SER_DATA: begin
        if (tick) begin
          d.rxo = q.rxo + 4'h1;
          if (q.rxo == OVS_END) begin
            d.rxsh = {rx_line, q.rxsh[7:1]};
            d.rxb = q.rxb + 3'h1;
            if (q.rxb == 3'h7) begin
              d.rxs = SER_STOP;
            end
          end
        end
      end
      SER_STOP: begin
        if (tick) begin
          d.rxo = q.rxo + 4'h1;
          if (q.rxo == OVS_END) begin
            d.rxs = SER_IDLE;
            if (!rx_line) begin
              d.fe = 1'b1;
            end
            if (q.rxc == FULL && !rpop) begin
              d.ovr = 1'b1;
            end else begin
              rpush = 1'b1;
            end
          end
        end
      end
    endcase

    // ****
    // FIFOs
    // ****
    if (tpush) begin // see RULE4
      d.txm[q.txw] = q.wd;
      d.txw = q.txw + PW'(1);
    end
    if (tpop) begin
      d.txr = q.txr + PW'(1);
    end
    d.txc = q.txc + CW'(tpush) - CW'(tpop);
    if (rpush) begin
      d.rxm[q.rxw] = q.rxsh;
      d.rxw = q.rxw + PW'(1);
    end
    if (rpop) begin
      d.rxr = q.rxr + PW'(1);
    end
    d.rxc = q.rxc + CW'(rpush) - CW'(rpop);
    // Queue reset bits act once and are not stored
    if (q.awh && q.wh && q.wbe && q.awi == IDX_IIR) begin
      if (q.wd[FCR_RXRST]) begin
        d.rxw = '0;
        d.rxr = '0;
        d.rxc = '0;
      end
      if (q.wd[FCR_TXRST]) begin
        d.txw = '0;
        d.txr = '0;
        d.txc = '0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    q <= aresetn ? d : ST_RST;
  end

  // ****
  // Outputs
  // ****
  assign s_awready = !q.awh && !q.bv;
  assign s_wready  = !q.wh && !q.bv;
  assign s_bvalid  = q.bv;
  assign s_bresp   = q.br;
  assign s_arready = !q.rv;
  assign s_rvalid  = q.rv;
  assign s_rdata   = {24'h000000, q.rd};
  assign s_rresp   = q.rr;

  // Loopback keeps the line idle high so the far end sees nothing
  assign serial_tx_out = q.txd || q.mcr[MCR_LOOP]; // see RULE1
  // Half-duplex releases the shared wire whenever not sending
  assign serial_tx_oe  = !q.mode[MODE_HDX] || (q.txs != SER_IDLE); // see RULE2
  assign sync_clock_out = q.sclk;

  // RS-485 direction: low while a character waits or is on the line
  assign request_to_send_out = q.mcr[MCR_LOOP] ? 1'b1 : // see RULE12
    (q.mode[MODE_485] ? !(q.txs != SER_IDLE || q.txc != '0) : // see RULE10
     !q.mcr[MCR_RTS]); // see RULE9
  assign terminal_ready_out = q.mcr[MCR_LOOP] ? 1'b1 : // see RULE12
    !q.mcr[MCR_DTR]; // see RULE11
endmodule
`default_nettype wire

// ===== dv/usmf_properties.sv
// Port checker for the modem front end, bound into usmf_top.
// Assumes AW and W of a write are offered in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module usmf_properties
  import usmf_pkg::*;
(
  input wire logic                        aclk, // Clock
  input wire logic                        aresetn, // Reset, low
  input wire logic                        s_awvalid, // AW valid
  input wire logic                        s_awready, // AW ready
  input wire logic [usmf_pkg::ADDR_W-1:0] s_awaddr, // AW address
  input wire logic                        s_wvalid, // W valid
  input wire logic                        s_wready, // W ready
  input wire logic [31:0]                 s_wdata, // W data
  input wire logic [3:0]                  s_wstrb, // W strobes
  input wire logic                        s_bvalid, // B valid
  input wire logic                        s_bready, // B ready
  input wire logic [1:0]                  s_bresp, // B response
  input wire logic                        s_arvalid, // AR valid
  input wire logic                        s_arready, // AR ready
  input wire logic                        s_rvalid, // R valid
  input wire logic                        s_rready, // R ready
  input wire logic [31:0]                 s_rdata, // R data
  input wire logic                        serial_tx_out, // Serial out
  input wire logic                        serial_tx_oe, // Drive enable
  input wire logic                        sync_clock_out, // Sync clock
  input wire logic                        clear_to_send_in, // Low active
  input wire logic                        request_to_send_out, // Low active
  input wire logic                        terminal_ready_out // Low active
);
  // ****
  // Shadow of control writes
  // ****
  typedef struct packed {
    logic [7:0] mcr;
    logic [3:0] mode;
    logic [2:0] quiet;
    logic [2:0] ctsh;
    logic [7:0] idle;
  } usmf_mon_t;
  usmf_mon_t  st_q, st_d;
  logic       wr;
  logic [3:0] ix;
  assign ix = s_awaddr[5:2];
  assign wr = s_awvalid && s_awready && s_wvalid && s_wready && s_wstrb[0];
  // Pins are only judged once a write has had time to land
  always_comb begin
    st_d = st_q;
    if (wr && ix == IDX_MCR) st_d.mcr = s_wdata[7:0];
    if (wr && ix == IDX_MODE) st_d.mode = s_wdata[3:0];
    st_d.quiet = st_q.quiet + {2'h0, st_q.quiet != 3'h7};
    if (wr && (ix == IDX_MCR || ix == IDX_MODE)) st_d.quiet = 3'h0;
    st_d.ctsh = clear_to_send_in ? st_q.ctsh + {2'h0, st_q.ctsh != 3'h7} : 3'h0;
    st_d.idle = serial_tx_out ? st_q.idle + {7'h0, st_q.idle != 8'hff} : 8'h0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) st_q <= '0;
    else st_q <= st_d;
  end
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  a_write_answer: assert property (wr_taken |-> ##[1:2] s_bvalid)
    else $error("write response late");
  a_bad_index: assert property (wr_taken ##0 (ix > IDX_MODE)
    |-> ##[1:2] (s_bvalid && s_bresp == RESP_SLV)) else $error("bad index not refused");
  a_b_stand: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  a_r_stand: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  a_rts_level: assert property (st_q.quiet > 3'h3 && !st_q.mode[MODE_485]
    |-> request_to_send_out == ~(st_q.mcr[MCR_RTS] & ~st_q.mcr[MCR_LOOP]))
    else $error("request to send wrong");
  a_dtr_level: assert property (st_q.quiet > 3'h3
    |-> terminal_ready_out == ~(st_q.mcr[MCR_DTR] & ~st_q.mcr[MCR_LOOP]))
    else $error("terminal ready wrong");
  a_full_oe: assert property (st_q.quiet > 3'h3 && !st_q.mode[MODE_HDX] |-> serial_tx_oe)
    else $error("line released outside half duplex");
  a_sync_idle: assert property (st_q.quiet > 3'h3 && !st_q.mode[MODE_SYNC] |-> !sync_clock_out)
    else $error("sync clock outside sync mode");
  a_cts_gate: assert property (st_q.mode[MODE_ACTS] && st_q.quiet == 3'h7
    && st_q.ctsh == 3'h7 && st_q.idle == 8'hff |=> serial_tx_out)
    else $error("start while clear to send high");
endmodule
bind usmf_top usmf_properties u_props (
  .aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_awaddr(s_awaddr), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata),
  .s_wstrb(s_wstrb), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid), .s_rready(s_rready),
  .s_rdata(s_rdata), .serial_tx_out(serial_tx_out), .serial_tx_oe(serial_tx_oe),
  .sync_clock_out(sync_clock_out), .clear_to_send_in(clear_to_send_in),
  .request_to_send_out(request_to_send_out), .terminal_ready_out(terminal_ready_out)
);
`default_nettype wire

// ===== dv/usmf_partner.sv
// Far-end serial equipment: modem status pins, a data line, a decoder.
// Assumes 8N1 at BIT_CYC clocks a bit, as the bench sets the divisor.
`timescale 1ns/10ps
`default_nettype none
module usmf_partner #(
  parameter int BIT_CYC = 16
) (
  input  wire logic       aclk,     // Clock
  input  wire logic [3:0] pin_low,  // Assert cts, dsr, ri, dcd
  input  wire logic       line_in,  // Line from the device
  output var  logic       line_out, // Our line, idle high
  output var  logic       cts_line, // Low active
  output var  logic       dsr_line, // Low active
  output var  logic       ri_line,  // Low active
  output var  logic       dcd_line, // Low active
  output var  logic [7:0] got,      // Last byte decoded
  output var  int         cnt       // Bytes decoded
);
  logic [7:0] sh;
  initial begin
    line_out = 1'b1;
    got = 8'h00;
    cnt = 0;
  end
  assign cts_line = ~pin_low[0];
  assign dsr_line = ~pin_low[1];
  assign ri_line  = ~pin_low[2];
  assign dcd_line = ~pin_low[3];
  // Start, LSB first, stop; stop level doubles as idle
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      line_out <= fr[i];
      repeat (BIT_CYC - 1) @(posedge aclk);
    end
  endtask
  // Samples at mid-bit, so an edge-time race cannot matter
  always begin
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge aclk);
      sh[i] = line_in;
    end
    repeat (BIT_CYC) @(posedge aclk);
    got = sh;
    cnt++;
  end
endmodule
`default_nettype wire

// ===== dv/usmf_tb_top.sv
// Self-checking bench of usmf_top with a far-end model.
// Assumes divisor 1 (16 clocks a bit) and the single-wire pull-up.
`timescale 1ns/10ps
`default_nettype none
module usmf_tb_top;
  import usmf_pkg::*;
  logic              aclk = 1'b0, aresetn = 1'b0, hdx = 1'b0, sclk_q = 1'b0;
  logic              s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic              s_arvalid = 1'b0, s_rready = 1'b0;
  logic [ADDR_W-1:0] s_awaddr = '0, s_araddr = '0;
  logic [31:0]       s_wdata = '0, s_rdata, rd;
  logic [3:0]        s_wstrb = '0, pin_low = '0;
  logic [1:0]        s_bresp, s_rresp, rsp;
  logic              s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic              tx, oe, sclk, rts, dtr, cts, dsr, dcd, ri, far_line;
  logic [7:0]        far_got;
  int                fail_count = 0, check_count = 0, rises = 0, far_cnt, s0;
  logic [3:0]        rix [4] = '{IDX_IIR, IDX_MCR, IDX_LCR, IDX_IER};
  logic [7:0]        rexp [4] = '{IIR_VAL, 8'h00, 8'h00, 8'h00};
  logic [7:0]        mcrv [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h13};
  logic [4:0]        trig [4] = '{TRIG_1, TRIG_4, TRIG_8, TRIG_14};
  // Single wire: released driver reads as the pull-up
  wire wl = (oe ? tx : 1'b1) & far_line;
  wire rx_in = hdx ? wl : far_line;
  wire far_rx = hdx ? wl : tx;
  always #2.5 aclk = ~aclk;
  usmf_top u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_awaddr(s_awaddr), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .s_rdata(s_rdata), .s_rresp(s_rresp), .serial_tx_out(tx),
    .serial_tx_oe(oe), .serial_rx_in(rx_in), .sync_clock_out(sclk), .clear_to_send_in(cts),
    .request_to_send_out(rts), .terminal_ready_out(dtr), .set_ready_in(dsr),
    .carrier_detect_in(dcd), .ring_indicator_in(ri)
  );
  usmf_partner #(.BIT_CYC(16)) u_far (
    .aclk(aclk), .pin_low(pin_low), .line_in(far_rx), .line_out(far_line), .cts_line(cts),
    .dsr_line(dsr), .ri_line(ri), .dcd_line(dcd), .got(far_got), .cnt(far_cnt)
  );
  always @(negedge aclk) begin
    sclk_q <= sclk;
    if (sclk === 1'b1 && sclk_q === 1'b0) rises++;
  end
  // ****
  // Bus tasks: ready and answers are taken at the rising edge
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ix, input logic [31:0] d);
    @(posedge aclk);
    s_awaddr <= {ix, 2'b00};
    s_wdata <= d;
    s_wstrb <= 4'hf;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] ix);
    @(posedge aclk);
    s_araddr <= {ix, 2'b00};
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    rd = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #250000;
    fail_count++;
    end_sim();
  end
  // ****
  // Tests
  // ****
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdr(rix[i]);
      chk(rd, {24'h0, rexp[i]});
    end
    wr(IDX_SCR, 32'ha5);
    rdr(IDX_SCR);
    chk(rd, 32'ha5);
    wr(4'h9, 32'hff);
    chk({30'h0, rsp}, {30'h0, RESP_SLV});
    rdr(4'h9);
    chk({rd[29:0], rsp}, {30'h0, RESP_SLV});
    for (int i = 0; i < 4; i++) begin
      pin_low <= 4'h1 << i;
      repeat (6) @(posedge aclk);
      rdr(IDX_MSR);
      chk(rd & 32'hf0, 32'h10 << i);
    end
    pin_low <= 4'h0;
    for (int i = 0; i < 5; i++) begin
      wr(IDX_MCR, {24'h0, mcrv[i]});
      repeat (4) @(posedge aclk);
      chk({rts, dtr}, {~(mcrv[i][1] & ~mcrv[i][4]), ~(mcrv[i][0] & ~mcrv[i][4])});
    end
    wr(IDX_DATA, 32'h5a);
    repeat (250) @(posedge aclk);
    rdr(IDX_DATA);
    chk(rd, 32'h5a);
    wr(IDX_MCR, 32'h0);
    wr(IDX_DATA, 32'h3c);
    u_far.send_byte(8'ha7);
    repeat (30) @(posedge aclk);
    chk({24'h0, far_got}, 32'h3c);
    rdr(IDX_DATA);
    chk(rd, 32'ha7);
    wr(IDX_MODE, 32'h4);
    s0 = far_cnt;
    for (int i = 0; i < 17; i++) wr(IDX_DATA, i);
    repeat (300) @(posedge aclk);
    chk(far_cnt - s0, 0);
    rdr(IDX_LSR);
    chk(rd & 32'h20, 32'h0);
    pin_low <= 4'h1;
    repeat (2900) @(posedge aclk);
    chk(far_cnt - s0, 16);
    chk({24'h0, far_got}, 32'hf);
    pin_low <= 4'h0;
    wr(IDX_MODE, 32'h0);
    wr(IDX_IIR, 32'h2);
    for (int i = 0; i < 4; i++) u_far.send_byte(8'h11);
    repeat (20) @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_IIR, i << 6);
      rdr(IDX_MODE);
      chk({31'h0, rd[7]}, {31'h0, trig[i] <= 5'h04});
    end
    wr(IDX_MODE, 32'h2);
    s0 = rises;
    wr(IDX_DATA, 32'h55);
    repeat (200) @(posedge aclk);
    chk(rises - s0, 8);
    wr(IDX_MODE, 32'h8);
    wr(IDX_DATA, 32'h0f);
    repeat (20) @(posedge aclk);
    chk({31'h0, rts}, 32'h0);
    repeat (200) @(posedge aclk);
    chk({31'h0, rts}, 32'h1);
    wr(IDX_IIR, 32'h2);
    wr(IDX_MODE, 32'h1);
    hdx <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({31'h0, oe}, 32'h0);
    u_far.send_byte(8'hc3);
    repeat (40) @(posedge aclk);
    rdr(IDX_DATA);
    chk(rd, 32'hc3);
    end_sim();
  end
endmodule
`default_nettype wire
